/* File: pkg/stfe_pkg.sv */
// ============================================================
// frame engine shared definitions
package stfe_pkg;

  localparam int STFE_FIELDS = 8;
  localparam int STFE_IDX_W  = 4;
  localparam int STFE_CNT_W  = 10;
  localparam int STFE_GAP_W  = 20;

  // ============================================================
  // line timing
  localparam longint STFE_CLK_HZ      = 20_000_000;
  localparam longint STFE_BAUD        = 9600;
  localparam longint STFE_CHAR_BITS   = 11;
  localparam longint STFE_GAP_HALVES  = 7;  // 3.5 characters
  localparam longint STFE_NS_PER_S    = 1_000_000_000;
  localparam longint STFE_GAP_NS      =
    (STFE_GAP_HALVES * STFE_CHAR_BITS * STFE_NS_PER_S + 2 * STFE_BAUD - 1)
    / (2 * STFE_BAUD);
  localparam int     STFE_GAP_CYC     =
    int'((STFE_GAP_NS * STFE_CLK_HZ + STFE_NS_PER_S - 1) / STFE_NS_PER_S);

  // ============================================================
  // checksum constants
  localparam logic [15:0] STFE_CRC_INIT = 16'hffff;
  localparam logic [15:0] STFE_CRC_POLY = 16'ha001;
  localparam logic [7:0]  STFE_HEX_DIG  = 8'h30;
  localparam logic [7:0]  STFE_HEX_LET  = 8'h37;

  // ============================================================
  // template description
  typedef enum logic [2:0] {
    STFE_F_END, STFE_F_NODE, STFE_F_CONST, STFE_F_LIMIT,
    STFE_F_DATA, STFE_F_VAR, STFE_F_CHECK
  } stfe_kind_type;

  typedef enum logic [1:0] {
    STFE_D_NONE, STFE_D_COUNT, STFE_D_END
  } stfe_delim_type;

  typedef enum logic [1:0] {
    STFE_C_CRC, STFE_C_LRC, STFE_C_XOR, STFE_C_ADD
  } stfe_chk_type;

  typedef enum logic [1:0] {
    STFE_M_NONE, STFE_M_ONES, STFE_M_TWOS
  } stfe_cmp_type;

  typedef struct packed {
    stfe_kind_type  kind;
    logic [2:0]     size;       // 1, 2 or 4 bytes
    logic [31:0]    value;      // constant, or lower bound
    logic [31:0]    upper;
    logic [9:0]     len;
    stfe_delim_type sub_delim;
    stfe_delim_type hl_delim;
    logic           keep_delim;
    logic [7:0]     end_char;
  } stfe_field_type;

  typedef struct packed {
    logic         produce;
    logic [7:0]   node;
    stfe_chk_type algo;
    stfe_cmp_type cmp;
    logic         ascii;
  } stfe_cfg_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } stfe_byte_type;

endpackage : stfe_pkg

/* File: rtl/stfe_cksum.sv */
`timescale 1ns/1ps
module stfe_cksum
  import stfe_pkg::*;
(
  input  wire logic         mclk_in,
  input  wire logic         rst_in,
  input  wire logic         clear_in,
  input  wire logic         valid_in,
  input  wire logic [7:0]   data_in,
  input  wire stfe_chk_type algo_in,
  output logic [15:0]       sum_out
);

  logic [15:0] crc;
  logic [7:0]  add8;
  logic [7:0]  xor8;
  logic [15:0] stage [9];

  // ============================================================
  // reflected crc, one stage per bit
  assign stage[0] = crc ^ {8'h00, data_in};
  for (genvar i = 0; i < 8; i++) begin : g_crc
    assign stage[i+1] = stage[i][0] ? ((stage[i] >> 1) ^ STFE_CRC_POLY)
                                    : (stage[i] >> 1);
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in || clear_in) begin
      crc  <= STFE_CRC_INIT;
      add8 <= 8'h00;
      xor8 <= 8'h00;
    end else if (valid_in) begin
      crc  <= stage[8];
      add8 <= add8 + data_in;
      xor8 <= xor8 ^ data_in;
    end
  end

  always_comb begin
    case (algo_in)
      STFE_C_CRC: sum_out = crc;
      STFE_C_LRC: sum_out = {8'h00, 8'(8'h00 - add8)};
      STFE_C_XOR: sum_out = {8'h00, xor8};
      default:    sum_out = {8'h00, add8};
    endcase
  end

endmodule : stfe_cksum

/* File: rtl/stfe_engine.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - node address field sends or expects the configured node byte.
// - produce constants go out unchanged, most significant byte first.
// - consume constants are compared; any mismatch discards the telegram.
// - a limit field in a produce template aborts with an error.
// - received limit values outside lower..upper discard the telegram.
// - produce data fields copy len bytes from high level input.
// - consume data field bytes are forwarded to the high level side.
// - consume counted variable data with keep_delim set gets an end byte generated if hl_delim is end, or its count byte forwarded if count.
// - consume variable data delimiter is forwarded or dropped per flag.
// - checksum is computed over the telegram and placed at its field.
// - direction flag selects produce or consume handling of all fields.
// - telegrams failing any check are ignored; engine rearms for next.
// - checksum is crc16, lrc, xor or add, complemented, binary or ascii.
// - silence of 3.5 characters ends a telegram and separates sends.
module stfe_engine
  import stfe_pkg::*;
#(
  parameter int GAP_CYCLES = STFE_GAP_CYC
) (
  input  wire logic           mclk_in,
  input  wire logic           rst_in,
  input  wire stfe_cfg_type   cfg_in,
  input  wire stfe_field_type tmpl_in [STFE_FIELDS],
  input  wire logic           start_in,
  input  wire logic           hl_valid_in,
  input  wire logic [7:0]     hl_data_in,
  output logic                hl_ready_out,
  output stfe_byte_type       tx_out,
  input  wire logic           tx_ready_in,
  input  wire stfe_byte_type  rx_in,
  output stfe_byte_type       fwd_out,
  output logic                busy_out,
  output logic                done_out,
  output logic                drop_out,
  output logic                err_out
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_FIELD, ST_FETCH, ST_SEND, ST_GAP, ST_RECV, ST_SKIP
  } stfe_state_type;

  stfe_state_type          state;
  logic [STFE_IDX_W-1:0]   idx;
  logic [STFE_CNT_W-1:0]   bcnt;
  logic [STFE_CNT_W-1:0]   vlen;
  logic [31:0]             acc;
  logic [7:0]              hold;
  logic                    have;
  logic                    got;
  logic                    gen_pend;
  logic [7:0]              gen_char;
  logic [STFE_GAP_W-1:0]   gap_cnt;
  stfe_field_type          fld;
  logic [15:0]             raw_sum;
  logic [15:0]             fin_sum;
  logic [7:0]              sum_byte;
  logic [3:0]              nib;
  logic [7:0]              chk_byte;
  logic [STFE_CNT_W-1:0]   chk_len;
  logic [7:0]              const_byte;
  logic [31:0]             mask;
  logic [31:0]             acc_n;
  logic                    gap_hit;
  logic                    chk_clear;
  logic                    chk_valid;
  logic [7:0]              chk_data;
  logic                    p_send, p_last, p_fetch, p_err, p_end, p_feed;
  logic [7:0]              p_byte;
  logic                    c_bad, c_fwd, c_last, c_feed, c_gen;

  // ============================================================
  // current field and derived values
  assign fld = (idx < STFE_IDX_W'(STFE_FIELDS)) ?
               tmpl_in[idx[2:0]] : '0;
  assign gap_hit = (gap_cnt == STFE_GAP_W'(GAP_CYCLES - 1));
  assign mask = (fld.size == 3'd1) ? 32'h0000_00ff :
                (fld.size == 3'd2) ? 32'h0000_ffff : 32'hffff_ffff;
  assign acc_n = {acc[23:0], rx_in.data};
  assign const_byte = 8'(fld.value >> {3'(fld.size - 3'd1 - bcnt[2:0]),
                                       3'b000});

  // ============================================================
  // checksum shaping
  always_comb begin
    case (cfg_in.cmp)
      STFE_M_ONES: fin_sum = ~raw_sum;
      STFE_M_TWOS: fin_sum = 16'(16'h0000 - raw_sum);
      default:     fin_sum = raw_sum;
    endcase
    if (cfg_in.algo != STFE_C_CRC) fin_sum[15:8] = 8'h00;
    chk_len = (cfg_in.algo == STFE_C_CRC) ? 10'h002 : 10'h001;
    if (cfg_in.ascii) chk_len = {chk_len[8:0], 1'b0};
    // crc goes low byte first, as on the serial bus
    if (cfg_in.ascii) sum_byte = (bcnt[1] ? fin_sum[15:8] : fin_sum[7:0]);
    else              sum_byte = (bcnt[0] ? fin_sum[15:8] : fin_sum[7:0]);
    nib = bcnt[0] ? sum_byte[3:0] : sum_byte[7:4];
    if (!cfg_in.ascii)      chk_byte = sum_byte;
    else if (nib < 4'ha)    chk_byte = STFE_HEX_DIG + {4'h0, nib};
    else                    chk_byte = STFE_HEX_LET + {4'h0, nib};
  end

  // ============================================================
  // produce step for the current field
  always_comb begin
    p_send  = 1'b0;
    p_last  = 1'b0;
    p_fetch = 1'b0;
    p_err   = 1'b0;
    p_end   = 1'b0;
    p_feed  = 1'b1;
    p_byte  = hold;
    case (fld.kind)
      STFE_F_NODE: begin
        p_send = 1'b1;
        p_byte = cfg_in.node;
        p_last = 1'b1;
      end
      STFE_F_CONST: begin
        p_send = 1'b1;
        p_byte = const_byte;
        p_last = (bcnt == STFE_CNT_W'(fld.size - 3'd1));
      end
      STFE_F_LIMIT: p_err = 1'b1;
      STFE_F_DATA: begin
        if (!have) p_fetch = 1'b1;
        else begin
          p_send = 1'b1;
          p_last = (bcnt == fld.len - 10'h001);
        end
      end
      STFE_F_VAR: begin
        if (!have) p_fetch = 1'b1;
        else begin
          case (fld.sub_delim)
            STFE_D_COUNT: begin
              if (bcnt == '0) begin
                p_send = fld.keep_delim;
                p_last = (hold == 8'h00);
              end else begin
                p_send = 1'b1;
                p_last = (bcnt == vlen);
              end
            end
            STFE_D_END: begin
              p_last = (hold == fld.end_char);
              p_send = p_last ? fld.keep_delim : 1'b1;
            end
            default: begin
              p_send = 1'b1;
              p_last = (bcnt == fld.len - 10'h001);
            end
          endcase
        end
      end
      STFE_F_CHECK: begin
        p_send = 1'b1;
        p_byte = chk_byte;
        p_feed = 1'b0;
        p_last = (bcnt == chk_len - 10'h001);
      end
      default: p_end = 1'b1;
    endcase
  end

  // ============================================================
  // consume check for one received byte
  always_comb begin
    c_bad  = 1'b0;
    c_fwd  = 1'b0;
    c_last = 1'b0;
    c_feed = 1'b1;
    c_gen  = 1'b0;
    case (fld.kind)
      STFE_F_NODE: begin
        c_bad  = (rx_in.data != cfg_in.node);
        c_last = 1'b1;
      end
      STFE_F_CONST: begin
        c_last = (bcnt == STFE_CNT_W'(fld.size - 3'd1));
        c_bad  = c_last && ((acc_n & mask) != (fld.value & mask));
      end
      STFE_F_LIMIT: begin
        c_last = (bcnt == STFE_CNT_W'(fld.size - 3'd1));
        c_bad  = c_last && (((acc_n & mask) < (fld.value & mask)) ||
                            ((acc_n & mask) > (fld.upper & mask)));
      end
      STFE_F_DATA: begin
        c_fwd  = 1'b1;
        c_last = (bcnt == fld.len - 10'h001);
      end
      STFE_F_VAR: begin
        case (fld.sub_delim)
          STFE_D_COUNT: begin
            if (bcnt == '0) begin
              c_fwd  = fld.keep_delim &&
                       (fld.hl_delim == STFE_D_COUNT);
              c_last = (rx_in.data == 8'h00);
            end else begin
              c_fwd  = 1'b1;
              c_last = (bcnt == vlen);
            end
          end
          STFE_D_END: begin
            c_last = (rx_in.data == fld.end_char);
            c_fwd  = c_last ? (fld.keep_delim &&
                               fld.hl_delim == STFE_D_END) : 1'b1;
          end
          default: c_fwd = 1'b1;
        endcase
        // end byte made locally when a counted field ends; the line carried none
        c_gen = c_last && fld.keep_delim && fld.hl_delim == STFE_D_END &&
                fld.sub_delim != STFE_D_END;
      end
      STFE_F_CHECK: begin
        c_feed = 1'b0;
        c_bad  = (rx_in.data != chk_byte);
        c_last = (bcnt == chk_len - 10'h001);
      end
      default: c_bad = 1'b1;
    endcase
  end

  // ============================================================
  // checksum unit
  assign chk_clear = (state == ST_IDLE);
  assign chk_valid = (state == ST_FIELD && p_send && p_feed) ||
                     (state == ST_RECV && rx_in.valid && c_feed);
  assign chk_data  = (state == ST_RECV) ? rx_in.data : p_byte;

  stfe_cksum u_cksum (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .clear_in (chk_clear),
    .valid_in (chk_valid),
    .data_in  (chk_data),
    .algo_in  (cfg_in.algo),
    .sum_out  (raw_sum)
  );

  // ============================================================
  // sequencing of both directions
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state        <= ST_IDLE;
      idx          <= '0;
      bcnt         <= '0;
      vlen         <= '0;
      acc          <= '0;
      hold         <= 8'h00;
      have         <= 1'b0;
      got          <= 1'b0;
      gap_cnt      <= '0;
      hl_ready_out <= 1'b0;
      busy_out     <= 1'b0;
      done_out     <= 1'b0;
      drop_out     <= 1'b0;
      err_out      <= 1'b0;
    end else begin
      done_out <= 1'b0;
      drop_out <= 1'b0;
      err_out  <= 1'b0;
      if (!gap_hit) gap_cnt <= gap_cnt + 1'b1;
      case (state)
        ST_IDLE: begin
          idx  <= '0;
          bcnt <= '0;
          acc  <= '0;
          have <= 1'b0;
          got  <= 1'b0;
          if (cfg_in.produce && start_in) begin
            busy_out <= 1'b1;
            state    <= ST_FIELD;
          end else if (!cfg_in.produce) begin
            state <= ST_RECV;
          end
        end
        ST_FIELD: begin
          if (p_end) begin
            done_out <= 1'b1;
            gap_cnt  <= '0;
            state    <= ST_GAP;
          end else if (p_err) begin
            err_out  <= 1'b1;
            busy_out <= 1'b0;
            state    <= ST_IDLE;
          end else if (p_fetch) begin
            hl_ready_out <= 1'b1;
            state        <= ST_FETCH;
          end else begin
            have <= 1'b0;
            if (fld.kind == STFE_F_VAR && bcnt == '0)
              vlen <= {2'b00, hold};
            if (p_last) begin
              idx  <= idx + 1'b1;
              bcnt <= '0;
            end else begin
              bcnt <= bcnt + 1'b1;
            end
            if (p_send) state <= ST_SEND;
          end
        end
        ST_FETCH: begin
          if (hl_valid_in) begin
            hold         <= hl_data_in;
            have         <= 1'b1;
            hl_ready_out <= 1'b0;
            state        <= ST_FIELD;
          end
        end
        ST_SEND: if (tx_ready_in) state <= ST_FIELD;
        ST_GAP: begin
          // quiet line before the next telegram may start
          if (gap_hit) begin
            busy_out <= 1'b0;
            state    <= ST_IDLE;
          end
        end
        ST_RECV: begin
          if (rx_in.valid) begin
            got      <= 1'b1;
            busy_out <= 1'b1;
            gap_cnt  <= '0;
            if (c_bad) begin
              state <= ST_SKIP;
            end else begin
              acc <= c_last ? '0 : acc_n;
              if (fld.kind == STFE_F_VAR && bcnt == '0)
                vlen <= {2'b00, rx_in.data};
              if (c_last) begin
                idx  <= idx + 1'b1;
                bcnt <= '0;
              end else begin
                bcnt <= bcnt + 1'b1;
              end
            end
          end else if (got && gap_hit) begin
            // an open-ended variable field completes at the gap
            if (fld.kind == STFE_F_END ||
                (fld.kind == STFE_F_VAR && fld.sub_delim == STFE_D_NONE))
              done_out <= 1'b1;
            else
              drop_out <= 1'b1;
            busy_out <= 1'b0;
            state    <= ST_IDLE;
          end
        end
        ST_SKIP: begin
          if (rx_in.valid) begin
            gap_cnt <= '0;
          end else if (gap_hit) begin
            drop_out <= 1'b1;
            busy_out <= 1'b0;
            state    <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ============================================================
  // serial transmit byte
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      tx_out <= '0;
    end else if (state == ST_FIELD && !p_end && !p_err && !p_fetch &&
                 p_send) begin
      tx_out <= '{valid: 1'b1, data: p_byte};
    end else if (state == ST_SEND && tx_ready_in) begin
      tx_out.valid <= 1'b0;
    end
  end

  // ============================================================
  // high level forward stream, no back-pressure
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      fwd_out  <= '0;
      gen_pend <= 1'b0;
      gen_char <= 8'h00;
    end else begin
      fwd_out  <= '0;
      gen_pend <= 1'b0;
      if (gen_pend) begin
        fwd_out <= '{valid: 1'b1, data: gen_char};
      end else if (state == ST_RECV && rx_in.valid && !c_bad) begin
        fwd_out  <= '{valid: c_fwd, data: rx_in.data};
        gen_pend <= c_gen;
        gen_char <= fld.end_char;
      end
    end
  end

endmodule : stfe_engine

/* File: test/serial_transaction_frame_engine_test.sv */
`timescale 1ns/1ps
module serial_transaction_frame_engine_test
  import stfe_pkg::*;
;
  localparam int GAP = 20;
  logic           mclk_in = 1'b0;
  logic           rst_in = 1'b1;
  logic           start_in = 1'b0;
  logic           hl_valid_in = 1'b0;
  logic           slow = 1'b0;
  logic [7:0]     hl_data_in = 8'h00;
  stfe_cfg_type   cfg = '0;
  stfe_field_type tmpl [STFE_FIELDS];
  logic           hl_ready_out, tx_ready, busy_out, done_out, drop_out;
  logic           err_out;
  stfe_byte_type  tx_out, rx, fwd_out;
  int             fail_count = 0, cmp_count = 0, hidx = 0;
  int             n_done = 0, n_drop = 0, n_err = 0;
  logic [7:0]     hq [$], fq [$], exp [$];

  always #25 mclk_in = !mclk_in;

  stfe_engine #(.GAP_CYCLES(GAP)) stfe_engine_i (
    .mclk_in(mclk_in), .rst_in(rst_in), .cfg_in(cfg), .tmpl_in(tmpl),
    .start_in(start_in), .hl_valid_in(hl_valid_in),
    .hl_data_in(hl_data_in), .hl_ready_out(hl_ready_out),
    .tx_out(tx_out), .tx_ready_in(tx_ready), .rx_in(rx),
    .fwd_out(fwd_out), .busy_out(busy_out), .done_out(done_out),
    .drop_out(drop_out), .err_out(err_out));

  stfe_node_model stfe_node_model_i (
    .mclk_in(mclk_in), .slow_in(slow), .tx_in(tx_out),
    .tx_ready_out(tx_ready), .rx_out(rx));

  // ====
  // high level side
  always @(posedge mclk_in) begin
    if (fwd_out.valid === 1'b1) fq.push_back(fwd_out.data);
    if (hl_valid_in && hl_ready_out === 1'b1) hidx++;
    n_done += int'(done_out === 1'b1);
    n_drop += int'(drop_out === 1'b1);
    n_err += int'(err_out === 1'b1);
  end

  // idle source shows a moving pattern, never the last byte
  always @(negedge mclk_in) begin
    hl_valid_in = hidx < hq.size();
    hl_data_in = hl_valid_in ? hq[hidx] : 8'h5a ^ 8'(hidx);
  end

  // ====
  // helpers
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  task automatic cmp_n(input int g, input int w, input string m);
    cmp_count++;
    if (g != w) begin
      fail_count++;
      $display("MISMATCH %0t %s got %0d want %0d", $time, m, g, w);
    end
  endtask : cmp_n

  task automatic cmp_q(input logic [7:0] g [$], input string m);
    bit bad;
    cmp_count++;
    bad = g.size() != exp.size();
    foreach (g[i]) if (!bad && g[i] !== exp[i]) bad = 1'b1;
    if (bad) begin
      fail_count++;
      $display("MISMATCH %0t %s got %p want %p", $time, m, g, exp);
    end
  endtask : cmp_q

  function automatic stfe_field_type f(input stfe_kind_type k,
      input logic [31:0] v, input logic [31:0] u, input logic [9:0] l);
    return '{k, 3'h1, v, u, l, STFE_D_NONE, STFE_D_NONE, 1'b0, 8'h0d};
  endfunction : f

  function automatic logic [15:0] crc16(input logic [7:0] q [$]);
    logic [15:0] c;
    c = STFE_CRC_INIT;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ STFE_CRC_POLY : c >> 1;
    end
    return c;
  endfunction : crc16

  task automatic clr;
    @(negedge mclk_in);
    rst_in = 1'b1;
    foreach (tmpl[i]) tmpl[i] = '0;
    hq.delete();
    fq.delete();
    stfe_node_model_i.got.delete();
  endtask : clr

  task automatic go(input logic prod, input stfe_chk_type a = STFE_C_CRC,
      input stfe_cmp_type m = STFE_M_NONE, input logic asc = 1'b0,
      input logic [7:0] nd = 8'h3c);
    cfg = '{prod, nd, a, m, asc};
    repeat (3) @(negedge mclk_in);
    rst_in = 1'b0;
    {hidx, n_done, n_drop, n_err} = '0;
  endtask : go

  task automatic kick(input int n);
    start_in = 1'b1;
    repeat (n) @(negedge mclk_in);
    start_in = 1'b0;
  endtask : kick

  task automatic wait_end;
    int i;
    for (i = 0; i < 600 && n_done + n_drop + n_err == 0; i++)
      @(negedge mclk_in);
    if (i == 600) begin
      fail_count++;
      $display("MISMATCH %0t no end of telegram", $time);
      report_and_stop();
    end
    repeat (GAP + 3) @(negedge mclk_in);
  endtask : wait_end

  // ====
  // scenarios
  task automatic t_produce;
    logic [15:0] c;
    clr();
    tmpl[0] = f(STFE_F_NODE, 0, 0, 1);
    tmpl[1] = f(STFE_F_CONST, 32'h1234, 0, 1);
    tmpl[1].size = 3'h2;
    tmpl[2] = f(STFE_F_DATA, 0, 0, 2);
    tmpl[3] = f(STFE_F_CHECK, 0, 0, 1);
    go(1'b1);
    slow = 1'b1;
    hq = '{8'h11, 8'h22};
    kick(2); // second start lands while busy
    wait_end();
    slow = 1'b0;
    exp = '{8'h3c, 8'h12, 8'h34, 8'h11, 8'h22};
    c = crc16(exp);
    exp.push_back(c[7:0]);
    exp.push_back(c[15:8]);
    cmp_q(stfe_node_model_i.got, "produce");
    cmp_n(n_done, 1, "done count");
    cmp_n(int'(busy_out === 1'b0), 1, "idle after gap");
    $display("t_produce finished");
  endtask : t_produce

  task automatic t_limit_produce;
    clr();
    tmpl[0] = f(STFE_F_LIMIT, 0, 32'hff, 1);
    tmpl[1] = f(STFE_F_NODE, 0, 0, 1);
    go(1'b1);
    kick(1);
    wait_end();
    exp = {};
    cmp_n(n_err, 1, "limit error");
    cmp_q(stfe_node_model_i.got, "nothing sent");
    $display("t_limit_produce finished");
  endtask : t_limit_produce

  // lrc, xor and add sums worked by hand over node a7 and constant c3; crc from crc16
  task automatic t_cksum;
    logic [15:0] c;
    for (int j = 0; j < 4; j++) begin
      clr();
      tmpl[0] = f(STFE_F_NODE, 0, 0, 1);
      tmpl[1] = f(STFE_F_CONST, 32'hc3, 0, 1);
      tmpl[2] = f(STFE_F_CHECK, 0, 0, 1);
      go(1'b1, stfe_chk_type'(j), stfe_cmp_type'(j % 3), j[0], 8'ha7);
      kick(1);
      wait_end();
      exp = '{8'ha7, 8'hc3};
      c = crc16(exp);
      case (j)
        0: exp = {exp, c[7:0], c[15:8]};
        1: exp = {exp, 8'h36, 8'h39};
        2: exp.push_back(8'h9c);
        default: exp = {exp, 8'h36, 8'h41};
      endcase
      cmp_q(stfe_node_model_i.got, "checksum variant");
      cmp_n(n_done, 1, "variant done");
    end
    $display("t_cksum finished");
  endtask : t_cksum

  task automatic t_var_produce;
    stfe_delim_type d;
    for (int j = 0; j < 4; j++) begin
      d = j[1] ? STFE_D_END : STFE_D_COUNT;
      clr();
      tmpl[0] = f(STFE_F_VAR, 0, 0, 16);
      tmpl[0].sub_delim = d;
      tmpl[0].hl_delim = d;
      tmpl[0].keep_delim = j[0];
      go(1'b1);
      exp = '{8'haa, 8'hbb};
      hq = exp;
      if (j[1]) hq.push_back(8'h0d);
      else hq.push_front(8'h02);
      if (j == 1) exp.push_front(8'h02);
      if (j == 3) exp.push_back(8'h0d);
      kick(1);
      wait_end();
      cmp_q(stfe_node_model_i.got, "var produce");
      cmp_n(hidx, 3, "source bytes used");
    end
    $display("t_var_produce finished");
  endtask : t_var_produce

  task automatic t_consume;
    logic [7:0] tc [6][4] = '{'{8'h3c, 8'ha5, 8'h0a, 8'h1},
      '{8'h3c, 8'ha5, 8'h14, 8'h1}, '{8'h3c, 8'ha4, 8'h10, 8'h0},
      '{8'h3c, 8'ha5, 8'h15, 8'h0}, '{8'h3c, 8'ha5, 8'h09, 8'h0},
      '{8'h3d, 8'ha5, 8'h10, 8'h0}};
    clr();
    tmpl[0] = f(STFE_F_NODE, 0, 0, 1);
    tmpl[1] = f(STFE_F_CONST, 32'ha5, 0, 1);
    tmpl[2] = f(STFE_F_LIMIT, 32'h0a, 32'h14, 1);
    tmpl[3] = f(STFE_F_DATA, 0, 0, 2);
    go(1'b0);
    repeat (2) @(negedge mclk_in);
    exp = '{8'h77, 8'h88};
    foreach (tc[i]) begin
      fq.delete();
      {n_done, n_drop} = '0;
      for (int b = 0; b < 3; b++) stfe_node_model_i.send(tc[i][b]);
      stfe_node_model_i.send(8'h77);
      stfe_node_model_i.send(8'h88);
      wait_end();
      cmp_n(n_done, int'(tc[i][3]), "kept");
      cmp_n(n_drop, int'(!tc[i][3]), "dropped");
      if (tc[i][3]) cmp_q(fq, "payload");
    end
    $display("t_consume finished");
  endtask : t_consume

  task automatic t_var_consume;
    for (int k = 0; k < 2; k++) begin
      clr();
      tmpl[0] = f(STFE_F_NODE, 0, 0, 1);
      tmpl[1] = f(STFE_F_VAR, 0, 0, 16);
      tmpl[1].sub_delim = STFE_D_COUNT;
      tmpl[1].hl_delim = STFE_D_END;
      tmpl[1].keep_delim = k[0];
      tmpl[1].end_char = 8'h3b;
      go(1'b0);
      repeat (2) @(negedge mclk_in);
      exp = '{8'h3c, 8'h02, 8'haa, 8'hbb};
      foreach (exp[i]) stfe_node_model_i.send(exp[i]);
      wait_end();
      exp = '{8'haa, 8'hbb};
      if (k == 1) exp.push_back(8'h3b);
      cmp_q(fq, "var consume");
      cmp_n(n_done, 1, "var kept");
    end
    $display("t_var_consume finished");
  endtask : t_var_consume

  initial begin
    foreach (tmpl[i]) tmpl[i] = '0;
    t_produce();
    t_limit_produce();
    t_cksum();
    t_var_produce();
    t_consume();
    t_var_consume();
    report_and_stop();
  end
endmodule : serial_transaction_frame_engine_test

/* File: test/stfe_engine_sva.sv */
`timescale 1ns/1ps
// ====
// port checks for the frame engine
module stfe_engine_sva
  import stfe_pkg::*;
#(
  parameter int GAP_CYCLES = 20
) (
  input wire logic          mclk_in,
  input wire logic          rst_in,
  input wire stfe_cfg_type  cfg_in,
  input wire logic          start_in,
  input wire logic          hl_ready_out,
  input wire stfe_byte_type tx_out,
  input wire logic          tx_ready_in,
  input wire stfe_byte_type fwd_out,
  input wire logic          busy_out,
  input wire logic          done_out,
  input wire logic          drop_out,
  input wire logic          err_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  a_start_goes_busy: assert property (
    start_in && !busy_out && cfg_in.produce |=> busy_out)
    else $error("start not taken");
  a_tx_consume_quiet: assert property (
    !cfg_in.produce |-> !tx_out.valid)
    else $error("byte sent in consume mode");
  a_tx_byte_held: assert property (
    tx_out.valid && !tx_ready_in |=> tx_out.valid && $stable(tx_out.data))
    else $error("serial byte changed before taken");
  a_hl_pull_dir: assert property (
    hl_ready_out |-> cfg_in.produce)
    else $error("high level byte wanted in consume");
  a_fwd_dir: assert property (
    fwd_out.valid |-> !cfg_in.produce)
    else $error("byte forwarded in produce");
  a_drop_not_done: assert property (
    drop_out |-> !done_out)
    else $error("telegram both kept and dropped");
  a_end_single: assert property (
    done_out || drop_out |=> !(done_out || drop_out))
    else $error("end pulse longer than one cycle");
  a_gap_busy: assert property (
    done_out && cfg_in.produce |=> busy_out [*8])
    else $error("quiet gap cut short");
  a_limit_abort: assert property (
    err_out |-> ##[0:2] !busy_out)
    else $error("limit in produce did not abort");

  c_done: cover property (done_out);
  c_drop: cover property (drop_out);
  c_err: cover property (err_out);
endmodule : stfe_engine_sva

bind stfe_engine stfe_engine_sva #(.GAP_CYCLES(GAP_CYCLES)) stfe_engine_sva_i (
  .mclk_in(mclk_in), .rst_in(rst_in), .cfg_in(cfg_in),
  .start_in(start_in), .hl_ready_out(hl_ready_out), .tx_out(tx_out),
  .tx_ready_in(tx_ready_in), .fwd_out(fwd_out), .busy_out(busy_out),
  .done_out(done_out), .drop_out(drop_out), .err_out(err_out));

/* File: test/stfe_node_model.sv */
`timescale 1ns/1ps
// ====
// serial node on the far side
module stfe_node_model
  import stfe_pkg::*;
(
  input  wire logic          mclk_in,
  input  wire logic          slow_in,
  input  wire stfe_byte_type tx_in,
  output logic               tx_ready_out,
  output stfe_byte_type      rx_out
);
  logic [7:0] got [$];
  logic       tog;

  initial begin
    tx_ready_out = 1'b1;
    rx_out = '0;
    tog = 1'b0;
  end

  // slow node takes a byte only every other cycle
  always @(negedge mclk_in) begin
    tog = !tog;
    tx_ready_out = !slow_in || tog;
  end

  always @(posedge mclk_in) begin
    if (tx_in.valid === 1'b1 && tx_ready_out)
      got.push_back(tx_in.data);
  end

  // bytes two cycles apart, far inside the telegram gap
  task automatic send(input logic [7:0] b);
    @(negedge mclk_in);
    rx_out = '{1'b1, b};
    @(negedge mclk_in);
    rx_out = '{1'b0, ~b};
  endtask : send
endmodule : stfe_node_model
